// [include/sfb_pkg.sv]
// constants, types and framing helpers for the serial flash buffer host
`default_nettype none
package sfb_pkg;

    // clock and link timing
    localparam int unsigned CLK_MHZ        = 40;
    localparam int unsigned CLK_PERIOD_NS  = 25;
    // sck half periods in mclk cycles; fast about 6.7 MHz, slow 5 MHz;
    // a fall-to-fall span under five cycles outruns the three-stage so sync
    localparam logic [7:0]  SCK_HALF_FAST  = 8'h03;
    localparam logic [7:0]  SCK_HALF_SLOW  = 8'h04;
    // chip select high time between frames
    localparam int unsigned CS_GAP_NS      = 50;
    localparam int unsigned CS_GAP_CYC_INT = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  CS_GAP_CYC     = CS_GAP_CYC_INT[7:0];
    // default longest erase plus program time, in microseconds
    localparam int unsigned EP_TIME_MAX_US = 40000;

    // opcodes
    localparam logic [7:0] OPC_RD_FAST_B1  = 8'hd4;
    localparam logic [7:0] OPC_RD_FAST_B2  = 8'hd6;
    localparam logic [7:0] OPC_RD_SLOW_B1  = 8'hd1;
    localparam logic [7:0] OPC_RD_SLOW_B2  = 8'hd3;
    localparam logic [7:0] OPC_WR_B1       = 8'h84;
    localparam logic [7:0] OPC_WR_B2       = 8'h87;
    localparam logic [7:0] OPC_PGM_ERS_B1  = 8'h83;
    localparam logic [7:0] OPC_PGM_ERS_B2  = 8'h86;
    localparam logic [7:0] OPC_PGM_B1      = 8'h88;
    localparam logic [7:0] OPC_PGM_B2      = 8'h89;
    localparam logic [7:0] OPC_THRU_B1     = 8'h82;
    localparam logic [7:0] OPC_THRU_B2     = 8'h85;
    localparam logic [7:0] DUMMY_BYTE      = 8'h00;

    // header length in bytes: opcode plus three address bytes, plus dummy
    localparam logic [2:0] HDR_LEN_PLAIN   = 3'h4;
    localparam logic [2:0] HDR_LEN_DUMMY   = 3'h5;

    typedef enum logic [2:0] {
        OP_RD_FAST   = 3'b000,
        OP_RD_SLOW   = 3'b001,
        OP_BUF_WR    = 3'b010,
        OP_PGM_ERASE = 3'b011,
        OP_PGM_PLAIN = 3'b100,
        OP_PGM_THRU  = 3'b101
    } op_t;

    function automatic logic [7:0] opcode_of(input op_t op, input logic buf2);
        logic [7:0] code;
        case (op)
            OP_RD_FAST:   code = buf2 ? OPC_RD_FAST_B2 : OPC_RD_FAST_B1;
            OP_RD_SLOW:   code = buf2 ? OPC_RD_SLOW_B2 : OPC_RD_SLOW_B1;
            OP_BUF_WR:    code = buf2 ? OPC_WR_B2 : OPC_WR_B1;
            OP_PGM_ERASE: code = buf2 ? OPC_PGM_ERS_B2 : OPC_PGM_ERS_B1;
            OP_PGM_PLAIN: code = buf2 ? OPC_PGM_B2 : OPC_PGM_B1;
            OP_PGM_THRU:  code = buf2 ? OPC_THRU_B2 : OPC_THRU_B1;
            default:      code = DUMMY_BYTE;
        endcase
        return code;
    endfunction

    // 24-bit address field for the three address bytes
    function automatic logic [23:0] addr_of(input op_t op, input logic mode512,
                                            input logic [11:0] page, input logic [9:0] idx);
        logic        paged;
        logic [23:0] a;
        paged = (op == OP_PGM_ERASE) || (op == OP_PGM_PLAIN) || (op == OP_PGM_THRU);
        if (!paged)
            a = mode512 ? {15'h0000, idx[8:0]} : {14'h0000, idx};
        else if (op == OP_PGM_THRU)
            a = mode512 ? {3'h0, page, idx[8:0]} : {2'h0, page, idx};
        else
            a = mode512 ? {3'h0, page, 9'h000} : {2'h0, page, 10'h000};
        return a;
    endfunction

    function automatic logic is_program(input op_t op);
        return (op == OP_PGM_ERASE) || (op == OP_PGM_PLAIN) || (op == OP_PGM_THRU);
    endfunction

endpackage
`default_nettype wire

// [include/shift_if.sv]
// byte shift request and answer between sequencer and serial engine
`default_nettype none
interface shift_if;
    logic       start;
    logic [7:0] tx;
    logic [7:0] half;
    logic       idle;
    logic       done;
    logic [7:0] rx;

    modport seq    (output start, output tx, output half, input idle, input done, input rx);
    modport engine (input start, input tx, input half, output idle, output done, output rx);
endinterface
`default_nettype wire

// [design/spi_shifter.sv]
// mode 0 byte shifter: makes sck by division, shifts si out, samples so in
`default_nettype none
module spi_shifter
(
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    shift_if.engine    sh,
    output logic       sck_o,
    output logic       si_o,
    input  wire logic  so_i
);
    import sfb_pkg::*;

    logic       busy_q;
    logic [7:0] half_q;
    logic [7:0] ph_q;
    logic [2:0] bit_q;
    logic       sck_q;
    logic [7:0] sr_q;
    logic [7:0] rx_q;
    logic       done_q;
    logic       s1_q;
    logic       s2_q;
    logic       s3_q;
    logic       so_q;

    wire ph_end = (ph_q == half_q - 8'h01);
    wire rise   = busy_q && ph_end && !sck_q;
    wire fall   = busy_q && ph_end && sck_q;
    wire last   = (bit_q == 3'h7);

    assign sh.idle = !busy_q;
    assign sh.done = done_q;
    assign sh.rx   = rx_q;
    assign sck_o   = sck_q;
    assign si_o    = sr_q[7];

    // so is asynchronous to mclk; a level counts once the later two stages agree
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            so_q <= 1'b0;
        end
        else
        begin
            s1_q <= so_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                so_q <= s3_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_q <= 1'b0;
            half_q <= SCK_HALF_SLOW;
            ph_q   <= 8'h00;
            bit_q  <= 3'h0;
            sck_q  <= 1'b0;
            sr_q   <= 8'h00;
            rx_q   <= 8'h00;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= fall && last;
            if (sh.start && !busy_q)
            begin
                busy_q <= 1'b1;
                half_q <= sh.half;
                ph_q   <= 8'h00;
                bit_q  <= 3'h0;
                sr_q   <= sh.tx;       // msb first
            end
            else if (busy_q)
            begin
                ph_q <= ph_end ? 8'h00 : ph_q + 8'h01;
                if (rise)
                    sck_q <= 1'b1;     // device samples si here
                if (fall)
                begin
                    sck_q <= 1'b0;
                    // sampled at the end of the high phase, so the sync delay
                    // still lands after the device's previous output change
                    rx_q  <= {rx_q[6:0], so_q};
                    sr_q  <= {sr_q[6:0], 1'b0};
                    bit_q <= bit_q + 3'h1;
                    if (last)
                        busy_q <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [design/sfb_host.sv]
// host sequencer for the serial flash buffer read, write and program commands
`default_nettype none
module sfb_host
#(
    parameter int unsigned EP_TIMEOUT_CYC = sfb_pkg::EP_TIME_MAX_US * sfb_pkg::CLK_MHZ,
    parameter logic [7:0]  STATUS_OPCODE  = 8'hd7,
    parameter int unsigned STATUS_RDY_BIT = 7,
    parameter int unsigned STATUS_EPE_BIT = 5
)
(
    input  wire logic               MCLK_I,
    input  wire logic               RST_N_I,
    input  wire logic               CMD_VALID_I,
    output logic                    CMD_READY_O,
    input  wire sfb_pkg::op_t       CMD_OP_I,
    input  wire logic               CMD_BUF2_I,
    input  wire logic               CMD_MODE512_I,
    input  wire logic [11:0]        CMD_PAGE_I,
    input  wire logic [9:0]         CMD_INDEX_I,
    input  wire logic [15:0]        CMD_LEN_I,
    input  wire logic [7:0]         WR_DATA_I,
    input  wire logic               WR_VALID_I,
    output logic                    WR_READY_O,
    output logic [7:0]              RD_DATA_O,
    output logic                    RD_VALID_O,
    output logic                    DONE_O,
    output logic                    FAIL_O,
    output logic                    TIMEOUT_O,
    output logic                    BUSY_O,
    output logic                    SPI_CS_N_O,
    output logic                    SPI_SCK_O,
    output logic                    SPI_SI_O,
    input  wire logic               SPI_SO_I
);
    import sfb_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR  = 3'b001,
        ST_DATA = 3'b010,
        ST_GAP  = 3'b011,
        ST_POLL = 3'b100,
        ST_PGAP = 3'b101,
        ST_DONE = 3'b110
    } state_t;

    state_t      state_q;
    state_t      state_d;
    op_t         op_q;
    logic        buf2_q;
    logic [23:0] addr_q;
    logic [15:0] len_q;
    logic [2:0]  hdr_cnt_q;
    logic [2:0]  hdr_len_q;
    logic [7:0]  half_q;
    logic        wait_q;
    logic [7:0]  gap_q;
    logic        poll_byte_q;
    logic [31:0] ep_cnt_q;
    logic        cs_n_q;
    logic [7:0]  rd_data_q;
    logic        rd_valid_q;
    logic        done_q;
    logic        fail_q;
    logic        tmo_q;
    logic        st_ready_q;

    shift_if sh ();

    spi_shifter u_shift
    (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .sh      (sh),
        .sck_o   (SPI_SCK_O),
        .si_o    (SPI_SI_O),
        .so_i    (SPI_SO_I)
    );

    // decoded command attributes
    wire is_rd      = (op_q == OP_RD_FAST) || (op_q == OP_RD_SLOW);
    wire is_wr      = (op_q == OP_BUF_WR) || (op_q == OP_PGM_THRU);
    wire is_pgm     = is_program(op_q);
    wire hdr_last   = (hdr_cnt_q == hdr_len_q - 3'h1);
    wire len_zero   = (len_q == 16'h0000);
    wire gap_end    = (gap_q == CS_GAP_CYC - 8'h01);
    wire ep_expired = (ep_cnt_q >= EP_TIMEOUT_CYC - 1);
    wire take_cmd   = CMD_VALID_I && (state_q == ST_IDLE);

    // status byte fields of the flash
    wire st_ready   = sh.rx[STATUS_RDY_BIT];
    wire st_fail    = sh.rx[STATUS_EPE_BIT];

    // header byte selected by count: opcode, three address bytes, dummy
    logic [7:0] hdr_byte;
    always_comb
    begin
        case (hdr_cnt_q)
            3'h0:    hdr_byte = opcode_of(op_q, buf2_q);
            3'h1:    hdr_byte = addr_q[23:16];
            3'h2:    hdr_byte = addr_q[15:8];
            3'h3:    hdr_byte = addr_q[7:0];
            default: hdr_byte = DUMMY_BYTE;
        endcase
    end

    // issue a byte to the engine when one is owed and none is in flight
    wire hdr_issue  = (state_q == ST_HDR) && !wait_q && sh.idle;
    wire rd_issue   = (state_q == ST_DATA) && is_rd && !len_zero && !wait_q && sh.idle;
    wire wr_issue   = (state_q == ST_DATA) && is_wr && !len_zero && !wait_q && sh.idle
                      && WR_VALID_I;
    wire poll_issue = (state_q == ST_POLL) && !wait_q && sh.idle;

    assign sh.start = hdr_issue || rd_issue || wr_issue || poll_issue;
    assign sh.half  = half_q;
    always_comb
    begin
        if (wr_issue)
            sh.tx = WR_DATA_I;
        else if (poll_issue)
            sh.tx = poll_byte_q ? DUMMY_BYTE : STATUS_OPCODE;
        else if (hdr_issue)
            sh.tx = hdr_byte;
        else
            sh.tx = DUMMY_BYTE;
    end

    // next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (CMD_VALID_I)
                    state_d = ST_HDR;
            ST_HDR:
                if (wait_q && sh.done && hdr_last)
                    // program-only commands end right after the address
                    state_d = (is_rd || is_wr) ? ST_DATA : ST_GAP;
            ST_DATA:
                // the frame only closes on a byte boundary
                if (len_zero && !wait_q)
                    state_d = ST_GAP;
            ST_GAP:
                if (gap_end)
                    state_d = is_pgm ? ST_POLL : ST_DONE;
            ST_POLL:
                if (wait_q && sh.done && poll_byte_q)
                    state_d = ST_PGAP;
            ST_PGAP:
                if (gap_end)
                    state_d = (fail_q || tmo_q || st_ready_q) ? ST_DONE : ST_POLL;
            ST_DONE:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // state register

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // command capture
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            op_q      <= OP_RD_SLOW;
            buf2_q    <= 1'b0;
            addr_q    <= 24'h000000;
            hdr_len_q <= HDR_LEN_PLAIN;
            half_q    <= SCK_HALF_SLOW;
        end
        else if (take_cmd)
        begin
            op_q      <= CMD_OP_I;
            buf2_q    <= CMD_BUF2_I;
            addr_q    <= addr_of(CMD_OP_I, CMD_MODE512_I, CMD_PAGE_I, CMD_INDEX_I);
            hdr_len_q <= (CMD_OP_I == OP_RD_FAST) ? HDR_LEN_DUMMY : HDR_LEN_PLAIN;
            // slow-grade reads run on the slower sck
            half_q    <= (CMD_OP_I == OP_RD_SLOW) ? SCK_HALF_SLOW : SCK_HALF_FAST;
        end
    end

    // byte bookkeeping: in-flight flag, header count, remaining data bytes
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wait_q    <= 1'b0;
            hdr_cnt_q <= 3'h0;
            len_q     <= 16'h0000;
        end
        else
        begin
            if (sh.start)
                wait_q <= 1'b1;
            else if (sh.done)
                wait_q <= 1'b0;
            if (take_cmd)
            begin
                hdr_cnt_q <= 3'h0;
                // program-only commands carry no data bytes
                len_q     <= is_program(CMD_OP_I) && (CMD_OP_I != OP_PGM_THRU)
                             ? 16'h0000 : CMD_LEN_I;
            end
            else if ((state_q == ST_HDR) && wait_q && sh.done)
                hdr_cnt_q <= hdr_cnt_q + 3'h1;
            else if ((state_q == ST_DATA) && wait_q && sh.done)
                len_q <= len_q - 16'h0001;
        end
    end

    // chip select low from the first header or status opcode byte to the last byte of each frame
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            cs_n_q <= 1'b1;
        else if (hdr_issue || poll_issue)
            cs_n_q <= 1'b0;
        else if ((state_d == ST_GAP) || (state_d == ST_PGAP))
            cs_n_q <= 1'b1;                        // rising select starts programming
    end

    // high time between frames
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            gap_q <= 8'h00;
        else if ((state_q == ST_GAP) || (state_q == ST_PGAP))
            gap_q <= gap_end ? 8'h00 : gap_q + 8'h01;
        else
            gap_q <= 8'h00;
    end

    // read data stream, one pulse per byte; the device wraps on its own
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= (state_q == ST_DATA) && is_rd && wait_q && sh.done;
            if ((state_q == ST_DATA) && is_rd && wait_q && sh.done)
                rd_data_q <= sh.rx;
        end
    end

    // status polling: opcode byte then one status byte per frame
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            poll_byte_q <= 1'b0;
            st_ready_q  <= 1'b0;
            fail_q      <= 1'b0;
            tmo_q       <= 1'b0;
            ep_cnt_q    <= 32'h00000000;
        end
        else
        begin
            if (take_cmd)
            begin
                poll_byte_q <= 1'b0;
                st_ready_q  <= 1'b0;
                fail_q      <= 1'b0;
                tmo_q       <= 1'b0;
                ep_cnt_q    <= 32'h00000000;
            end
            else
            begin
                if ((state_q == ST_POLL) && wait_q && sh.done)
                begin
                    poll_byte_q <= !poll_byte_q;
                    if (poll_byte_q)
                    begin
                        st_ready_q <= st_ready;
                        fail_q     <= st_ready && st_fail;
                    end
                end
                // the device must finish inside the longest stated time
                if ((state_q == ST_POLL) || (state_q == ST_PGAP))
                begin
                    if (ep_expired)
                        tmo_q <= 1'b1;
                    else
                        ep_cnt_q <= ep_cnt_q + 32'h00000001;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            done_q <= 1'b0;
        else
            done_q <= (state_q == ST_DONE);
    end

    // plain program needs a pre-erased page; the caller owns that
    assign CMD_READY_O = (state_q == ST_IDLE);
    assign WR_READY_O  = wr_issue;
    assign RD_DATA_O   = rd_data_q;
    assign RD_VALID_O  = rd_valid_q;
    assign DONE_O      = done_q;
    assign FAIL_O      = fail_q;
    assign TIMEOUT_O   = tmo_q;
    assign BUSY_O      = (state_q != ST_IDLE);
    assign SPI_CS_N_O  = cs_n_q;
endmodule
`default_nettype wire

// [verif/sfb_props.sv]
// concurrent checks on the flash buffer host ports
`default_nettype none
module sfb_props
(
    input  wire logic MCLK_I,
    input  wire logic RST_N_I,
    input  wire logic CMD_VALID_I,
    input  wire logic CMD_READY_O,
    input  wire logic BUSY_O,
    input  wire logic WR_VALID_I,
    input  wire logic WR_READY_O,
    input  wire logic RD_VALID_O,
    input  wire logic DONE_O,
    input  wire logic SPI_CS_N_O,
    input  wire logic SPI_SCK_O,
    input  wire logic SPI_SI_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_open;
        BUSY_O ##[0:1] !SPI_CS_N_O;
    endsequence
    property p_take;
        CMD_VALID_I && CMD_READY_O |=> s_open;
    endproperty
    a_take: assert property (p_take) else $error("frame not opened");
    property p_sck_framed;
        SPI_SCK_O |-> !SPI_CS_N_O;
    endproperty
    a_sck_framed: assert property (p_sck_framed) else $error("sck outside frame");
    property p_si_hold;
        SPI_SCK_O && $past(SPI_SCK_O) |-> $stable(SPI_SI_O);
    endproperty
    a_si_hold: assert property (p_si_hold) else $error("si moved while sck high");
    property p_half;
        $rose(SPI_SCK_O) |-> SPI_SCK_O [*2];
    endproperty
    a_half: assert property (p_half) else $error("sck high too short");
    property p_cs_gap;
        $rose(SPI_CS_N_O) |-> SPI_CS_N_O [*2];
    endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
    property p_done;
        DONE_O |-> !BUSY_O ##1 !DONE_O;
    endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_rd;
        RD_VALID_O |-> BUSY_O ##1 !RD_VALID_O;
    endproperty
    a_rd: assert property (p_rd) else $error("read pulse wrong");
    property p_wr;
        WR_READY_O |-> WR_VALID_I && !SPI_CS_N_O;
    endproperty
    a_wr: assert property (p_wr) else $error("write byte outside frame");
endmodule
bind sfb_host sfb_props sfb_props_i (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O), .BUSY_O(BUSY_O),
    .WR_VALID_I(WR_VALID_I), .WR_READY_O(WR_READY_O), .RD_VALID_O(RD_VALID_O),
    .DONE_O(DONE_O), .SPI_CS_N_O(SPI_CS_N_O), .SPI_SCK_O(SPI_SCK_O), .SPI_SI_O(SPI_SI_O));
`default_nettype wire

// [verif/flash_model.sv]
// behavioural serial flash with two page buffers and status polling
`default_nettype none
module flash_model
(
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic       si_i,
    output logic            so_o,
    input  wire logic       m512_i,
    input  wire logic       fail_i,
    input  wire logic [7:0] polls_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  buf_q [2][528];
    logic [7:0]  sh_q, opc_q, cmd_q, busy_q;
    logic [23:0] adr_q;
    logic        epe_q, bsel;
    int          nb, ptr, sz, dst;
    assign sz = m512_i ? 512 : 528;
    assign dst = (opc_q inside {8'hd4, 8'hd6}) ? 40 : 32;
    assign bsel = opc_q inside {8'hd6, 8'hd3, 8'h87, 8'h86, 8'h89, 8'h85};
    initial
    begin
        so_o = 1'b0;
        opc_q = 8'h00;
        busy_q = 8'h00;
        epe_q = 1'b0;
    end
    always @(negedge cs_n_i) nb = 0;
    always @(posedge cs_n_i)
    begin
        so_o = ~so_o;
        if (opc_q == 8'hd7 && busy_q != 8'h00)
            busy_q--;
        else if (opc_q inside {8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85})
        begin
            busy_q = polls_i;
            epe_q = fail_i;
        end
    end
    always @(posedge sck_i)
    if (!cs_n_i)
    begin
        sh_q = {sh_q[6:0], si_i};
        nb++;
        if (nb == 8)
            opc_q = sh_q;
        if (nb == 8 && sh_q != 8'hd7)
            cmd_q = sh_q;
        if (nb > 8 && nb <= 32 && nb % 8 == 0 && opc_q != 8'hd7)
            adr_q = {adr_q[15:0], sh_q};
        if (nb == 32)
            ptr = (m512_i ? adr_q[8:0] : adr_q[9:0]) % sz;
        if (nb > 32 && nb % 8 == 0 && opc_q inside {8'h84, 8'h87, 8'h82, 8'h85})
        begin
            buf_q[bsel][ptr] = sh_q;
            ptr = (ptr + 1) % sz;
        end
    end
    always @(negedge sck_i)
    if (!cs_n_i && opc_q == 8'hd7 && nb >= 8)
        so_o = (nb % 8 == 0) ? (busy_q == 8'h00) : (nb % 8 == 2) ? epe_q : 1'b0;
    else if (!cs_n_i && opc_q inside {8'hd4, 8'hd6, 8'hd1, 8'hd3} && nb >= dst)
        so_o = buf_q[bsel][(ptr + (nb - dst) / 8) % sz][7 - nb % 8];
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the flash buffer host
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfb_pkg::*;
    logic        mclk, rst_n, cmd_valid, cmd_ready, b2, m512, wr_valid, wr_ready;
    logic        rd_valid, done, fail, tmo, busy, cs_n, sck, si, so, fl;
    op_t         op;
    logic [11:0] page;
    logic [9:0]  idx;
    logic [15:0] len;
    logic [7:0]  wr_data, rd_data, polls;
    logic [7:0]  img [2][528];
    logic [7:0]  wq[$], rq[$];
    int          n_fail, checks_done;
    logic [7:0]  opc_tab [6][2] = '{'{8'hd4, 8'hd6}, '{8'hd1, 8'hd3}, '{8'h84, 8'h87},
                                    '{8'h83, 8'h86}, '{8'h88, 8'h89}, '{8'h82, 8'h85}};
    sfb_host #(.EP_TIMEOUT_CYC(2000)) sfb_host_i (.MCLK_I(mclk), .RST_N_I(rst_n),
        .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_OP_I(op), .CMD_BUF2_I(b2),
        .CMD_MODE512_I(m512), .CMD_PAGE_I(page), .CMD_INDEX_I(idx), .CMD_LEN_I(len),
        .WR_DATA_I(wr_data), .WR_VALID_I(wr_valid), .WR_READY_O(wr_ready),
        .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .DONE_O(done), .FAIL_O(fail),
        .TIMEOUT_O(tmo), .BUSY_O(busy), .SPI_CS_N_O(cs_n), .SPI_SCK_O(sck),
        .SPI_SI_O(si), .SPI_SO_I(so));
    flash_model flash_model_i (.cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so),
        .m512_i(m512), .fail_i(fl), .polls_i(polls));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic check(string what, logic [23:0] exp, logic [23:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // write stream changes only on falling edges, pops on the taking edge
    always @(negedge mclk)
    begin
        wr_valid <= wq.size() > 0;
        wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
    end
    always @(posedge mclk)
    if (wr_ready === 1'b1 && wr_valid === 1'b1)
        void'(wq.pop_front());
    always @(negedge mclk)
    if (rd_valid === 1'b1)
    begin
        if (rq.size() == 0)
            check("surplus read", 24'h0, 24'h1);
        else
            check("read byte", {16'h0, rq.pop_front()}, {16'h0, rd_data});
    end
    task automatic cmd(op_t o, logic bb, logic mm, logic [9:0] ix, int n, logic ff,
                       logic [7:0] pl);
        int          i;
        int          sz;
        logic [23:0] ea;
        logic [7:0]  d;
        sz = mm ? 512 : 528;
        @(negedge mclk);
        op = o;
        b2 = bb;
        m512 = mm;
        page = 12'($urandom);
        idx = ix;
        len = 16'(n);
        fl = ff;
        polls = pl;
        cmd_valid = 1'b1;
        ea = (o >= OP_PGM_ERASE) ? (mm ? {3'h0, page, 9'h0} : {2'h0, page, 10'h0}) : 24'h0;
        if (o != OP_PGM_ERASE && o != OP_PGM_PLAIN)
            ea = ea | (mm ? 24'(ix[8:0]) : 24'(ix));
        for (i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            if (o == OP_BUF_WR || o == OP_PGM_THRU)
            begin
                wq.push_back(d);
                img[bb][(ix + i) % sz] = d;
            end
            else
                rq.push_back(img[bb][(ix + i) % sz]);
        end
        @(negedge mclk);
        cmd_valid = 1'b0;
        i = 0;
        while (done !== 1'b1 && i < 20000)
        begin
            @(negedge mclk);
            i++;
        end
        if (i == 20000)
        begin
            n_fail++;
            $display("[FAIL] done expected 1 seen 0");
            finish_test();
        end
        check("opcode", {16'h0, opc_tab[o][bb]}, {16'h0, flash_model_i.cmd_q});
        check("address", ea, flash_model_i.adr_q);
        check("fail flag", {23'h0, ff && pl < 40}, {23'h0, fail});
        check("timeout flag", {23'h0, pl > 40}, {23'h0, tmo});
        check("reads left", 24'h0, 24'(rq.size()));
        $display("test op %0d buffer %0d done", o, bb);
    endtask
    initial
    begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        op = OP_RD_FAST;
        {b2, m512, fl} = 3'h0;
        {page, idx, len, polls} = 46'h0;
        n_fail = 0;
        checks_done = 0;
        void'($urandom(90886));
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        cmd(OP_BUF_WR, 1'b0, 1'b0, 10'h20e, 4, 1'b0, 8'h00);
        cmd(OP_RD_FAST, 1'b0, 1'b0, 10'h20e, 4, 1'b0, 8'h00);
        cmd(OP_RD_SLOW, 1'b0, 1'b0, 10'h20f, 3, 1'b0, 8'h00);
        cmd(OP_BUF_WR, 1'b1, 1'b1, 10'h1fe, 4, 1'b0, 8'h00);
        cmd(OP_RD_FAST, 1'b1, 1'b1, 10'h1ff, 3, 1'b0, 8'h00);
        cmd(OP_RD_SLOW, 1'b1, 1'b1, 10'h1fe, 3, 1'b0, 8'h00);
        cmd(OP_PGM_ERASE, 1'b0, 1'b0, 10'h000, 0, 1'b1, 8'h03);
        cmd(OP_PGM_ERASE, 1'b1, 1'b1, 10'h000, 0, 1'b0, 8'h00);
        cmd(OP_PGM_PLAIN, 1'b1, 1'b1, 10'h000, 0, 1'b1, 8'h02);
        cmd(OP_PGM_PLAIN, 1'b0, 1'b0, 10'h000, 0, 1'b0, 8'h05);
        cmd(OP_PGM_THRU, 1'b0, 1'b0, 10'h20f, 3, 1'b0, 8'h03);
        cmd(OP_PGM_THRU, 1'b1, 1'b1, 10'h1ff, 2, 1'b1, 8'h04);
        cmd(OP_RD_FAST, 1'b0, 1'b0, 10'h20f, 3, 1'b0, 8'h00);
        cmd(OP_PGM_ERASE, 1'b0, 1'b0, 10'h000, 0, 1'b0, 8'h3c);
        finish_test();
    end
endmodule
`default_nettype wire
